// ### ydt_pkg.sv
// ydt_pkg: constants and carrier types for the yearly date timer.
// assumes a 32-bit apb3 master and an rtc that presents binary date fields.
package ydt_pkg;
	localparam int unsigned CLK_HZ = 125_000_000;
	localparam int unsigned ADDR_W = 8;

	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_ON_DATE = 8'h04;
	localparam logic [7:0] OFS_OFF_DATE = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;

	// control field positions
	localparam int unsigned CTRL_MONTHLY = 0;
	localparam int unsigned CTRL_YEARLY = 1;
	localparam int unsigned CTRL_PULSE = 2;
	localparam int unsigned CTRL_ENABLE = 3;
	localparam logic [3:0] CTRL_RST = 4'h0;

	// date word layout: day, month, full year
	localparam int unsigned DAY_LSB = 0;
	localparam int unsigned MON_LSB = 8;
	localparam int unsigned YEAR_LSB = 16;

	// status field positions
	localparam int unsigned STAT_Q = 0;
	localparam int unsigned STAT_SPAN = 1;
	localparam int unsigned STAT_EVAL = 2;

	// calendar limits
	localparam logic [11:0] YEAR_MIN = 12'h7D0;
	localparam logic [11:0] YEAR_MAX = 12'h833;
	localparam logic [3:0] MON_MIN = 4'h1;
	localparam logic [3:0] MON_MAX = 4'hC;
	localparam logic [4:0] DAY_MIN = 5'h01;
	localparam logic [4:0] DAY_MAX = 5'h1F;
	localparam logic [4:0] MIDNIGHT_HOUR = 5'h00;
	localparam logic [5:0] MIDNIGHT_MIN = 6'h00;

	// stored date: year kept as offset from the first legal year
	typedef struct packed {
		logic [6:0] yoff;
		logic [3:0] month;
		logic [4:0] day;
	} ydt_date_t;

	localparam ydt_date_t DATE_RST = '{yoff: 7'h00, month: 4'h1, day: 5'h01};

	// current time from the real-time clock
	typedef struct packed {
		logic [11:0] year;
		logic [3:0] month;
		logic [4:0] day;
		logic [4:0] hour;
		logic [5:0] minute;
	} ydt_rtc_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0] pwdata;
	} ydt_apb_req_t;
endpackage : ydt_pkg

// ### ydt_timer.sv
// ydt_timer: calendar-driven on/off switch with apb3 register access.
// assumes rtc fields come from logic on clk_sys and scan_tick marks a program cycle.
//
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/10ps

module ydt_timer (
	input wire logic clk_sys, // system clock, 125 MHz
	input wire logic reset, // synchronous reset, active high
	input wire ydt_pkg::ydt_apb_req_t apb_req, // apb request group
	output logic pready, // apb ready
	output logic [31:0] prdata, // apb read data
	output logic pslverr, // apb error answer
	input wire ydt_pkg::ydt_rtc_t rtc_now, // current rtc date and time
	input wire logic scan_tick, // one pulse per program cycle
	output logic timer_q // switched output
);
	logic [3:0] ctrl;
	ydt_pkg::ydt_date_t on_date;
	ydt_pkg::ydt_date_t off_date;
	ydt_pkg::ydt_date_t last_date;
	logic evaluated;
	logic span_on;

	logic setup_phase;
	logic access_wr;
	logic sel_ctrl;
	logic sel_on;
	logic sel_off;
	logic sel_stat;
	logic addr_hit;
	logic next_err;
	logic wr_ctrl;
	logic wr_on;
	logic wr_off;
	logic wdate_ok;
	ydt_pkg::ydt_date_t wdate;
	logic [11:0] wyear;
	logic [11:0] year_off;

	logic now_ok;
	ydt_pkg::ydt_date_t now;
	logic new_day;
	logic at_midnight;
	logic in_years;
	logic [8:0] md_now;
	logic [8:0] md_on;
	logic [8:0] md_off;
	logic [15:0] full_now;
	logic [15:0] full_on;
	logic [15:0] full_off;
	logic next_span;
	logic next_pulse;
	logic mode_monthly;
	logic mode_yearly;
	logic mode_pulse;

	// apb slave
	// zero wait state: read data is captured at the setup edge so it comes from a flop
	assign pready = 1'b1;
	assign setup_phase = apb_req.psel && !apb_req.penable;
	assign access_wr = apb_req.psel && apb_req.penable && apb_req.pwrite;

	assign sel_ctrl = apb_req.paddr == ydt_pkg::OFS_CTRL;
	assign sel_on = apb_req.paddr == ydt_pkg::OFS_ON_DATE;
	assign sel_off = apb_req.paddr == ydt_pkg::OFS_OFF_DATE;
	assign sel_stat = apb_req.paddr == ydt_pkg::OFS_STATUS;

	assign wr_ctrl = access_wr && sel_ctrl;
	assign wr_on = access_wr && sel_on && wdate_ok;
	assign wr_off = access_wr && sel_off && wdate_ok;

	// decode a written date word: year, month, day fields
	assign wyear = apb_req.pwdata[ydt_pkg::YEAR_LSB +: 12];
	assign year_off = wyear - ydt_pkg::YEAR_MIN;
	assign wdate.yoff = year_off[6:0];
	assign wdate.month = apb_req.pwdata[ydt_pkg::MON_LSB +: 4];
	assign wdate.day = apb_req.pwdata[ydt_pkg::DAY_LSB +: 5];

	// out-of-range dates are refused with an error and leave the old date in place
	assign wdate_ok = wyear >= ydt_pkg::YEAR_MIN && wyear <= ydt_pkg::YEAR_MAX
		&& wdate.month >= ydt_pkg::MON_MIN && wdate.month <= ydt_pkg::MON_MAX
		&& wdate.day >= ydt_pkg::DAY_MIN && wdate.day <= ydt_pkg::DAY_MAX;

	assign addr_hit = sel_ctrl || sel_on || sel_off || sel_stat;

	// a date write with a field out of range is refused, the rest only by address
	always_comb begin
		next_err = 1'b0;
		if (!addr_hit) begin
			next_err = 1'b1;
		end else if (apb_req.pwrite && (sel_on || sel_off)) begin
			next_err = !wdate_ok;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			pslverr <= 1'b0;
		end else if (setup_phase) begin
			pslverr <= next_err;
		end
	end

	function automatic logic [31:0] date_word(input ydt_pkg::ydt_date_t d);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[ydt_pkg::YEAR_LSB +: 12] = ydt_pkg::YEAR_MIN + {5'h00, d.yoff};
		w[ydt_pkg::MON_LSB +: 4] = d.month;
		w[ydt_pkg::DAY_LSB +: 5] = d.day;
		return w;
	endfunction : date_word

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			prdata <= 32'h0000_0000;
		end else if (setup_phase && !apb_req.pwrite) begin
			prdata <= 32'h0000_0000;
			if (sel_ctrl) begin
				prdata <= {28'h000_0000, ctrl};
			end
			if (sel_on) begin
				prdata <= date_word(on_date);
			end
			if (sel_off) begin
				prdata <= date_word(off_date);
			end
			if (sel_stat) begin
				prdata <= {29'h000_0000, evaluated, span_on, timer_q};
			end
		end
	end

	// configuration
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			ctrl <= ydt_pkg::CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl <= apb_req.pwdata[3:0];
		end
	end

	// pslverr was decided at setup from the same held pwdata, so the checks agree
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			on_date <= ydt_pkg::DATE_RST;
			off_date <= ydt_pkg::DATE_RST;
		end else begin
			if (wr_on) begin
				on_date <= wdate;
			end
			if (wr_off) begin
				off_date <= wdate;
			end
		end
	end

	assign mode_monthly = ctrl[ydt_pkg::CTRL_MONTHLY];
	assign mode_yearly = ctrl[ydt_pkg::CTRL_YEARLY];
	assign mode_pulse = ctrl[ydt_pkg::CTRL_PULSE];

	// schedule evaluation
	logic [11:0] now_yoff;
	logic last_ok;
	logic first_year;
	logic final_year;
	logic day_start;
	logic day_carry;
	logic md_start;
	logic md_carry;
	logic span_single;
	logic span_yearly;
	logic span_monthly;
	logic pulse_single;
	logic pulse_yearly;
	logic pulse_monthly;
	logic span_load;
	logic q_load;
	logic next_q;

	assign now_yoff = rtc_now.year - ydt_pkg::YEAR_MIN;
	assign now.yoff = now_yoff[6:0];
	assign now.month = rtc_now.month;
	assign now.day = rtc_now.day;
	assign now_ok = rtc_now.year >= ydt_pkg::YEAR_MIN && rtc_now.year <= ydt_pkg::YEAR_MAX;

	// compare keys ordered year, month, day so plain magnitude gives date order
	assign full_now = now;
	assign full_on = on_date;
	assign full_off = off_date;
	assign md_now = {now.month, now.day};
	assign md_on = {on_date.month, on_date.day};
	assign md_off = {off_date.month, off_date.day};

	// year bounds shared by the monthly and yearly repeats
	assign in_years = now.yoff >= on_date.yoff && now.yoff <= off_date.yoff;
	assign first_year = now.yoff == on_date.yoff;
	assign final_year = now.yoff == off_date.yoff;

	assign at_midnight = rtc_now.hour == ydt_pkg::MIDNIGHT_HOUR
		&& rtc_now.minute == ydt_pkg::MIDNIGHT_MIN;
	// the level state moves only when the date moves, which is at 00:00;
	// an out-of-range year can alias a legal offset, so its flag is part of the key
	assign new_day = !evaluated || now != last_date || now_ok != last_ok;

	// single span: from the full on date up to, not including, the full off date
	assign span_single = full_now >= full_on && full_now < full_off;

	// yearly repeat on month and day
	assign md_start = md_now >= md_on;
	assign md_carry = md_now < md_off;

	always_comb begin
		span_yearly = 1'b0;
		if (!in_years) begin
			span_yearly = 1'b0;
		end else if (md_on <= md_off) begin
			span_yearly = md_start && md_carry;
		end else begin
			// crosses new year: no fresh start in the final year, no carry-in in the first
			span_yearly = (md_start && !final_year)
				|| (md_carry && !first_year);
		end
	end

	// monthly repeat on the day of month only
	assign day_start = now.day >= on_date.day;
	assign day_carry = now.day < off_date.day;

	always_comb begin
		span_monthly = 1'b0;
		if (!in_years) begin
			span_monthly = 1'b0;
		end else if (on_date.day <= off_date.day) begin
			span_monthly = day_start && day_carry;
		end else begin
			// wraps into the next month: no start in december of the final year
			// and no carry-in in january of the first year
			span_monthly = (day_start && !(final_year && now.month == ydt_pkg::MON_MAX))
				|| (day_carry && !(first_year && now.month == ydt_pkg::MON_MIN));
		end
	end

	// monthly wins over yearly; with both set the year bounds are the same
	always_comb begin
		next_span = 1'b0;
		if (!now_ok) begin
			next_span = 1'b0;
		end else if (mode_monthly) begin
			next_span = span_monthly;
		end else if (mode_yearly) begin
			next_span = span_yearly;
		end else begin
			next_span = span_single;
		end
	end

	// pulse ignores the off month and day, only its year bounds the repeats
	assign pulse_single = full_now == full_on;
	assign pulse_yearly = in_years && md_now == md_on;
	assign pulse_monthly = in_years && now.day == on_date.day;

	always_comb begin
		next_pulse = 1'b0;
		if (!now_ok || !at_midnight) begin
			next_pulse = 1'b0;
		end else if (mode_monthly) begin
			next_pulse = pulse_monthly;
		end else if (mode_yearly) begin
			next_pulse = pulse_yearly;
		end else begin
			next_pulse = pulse_single;
		end
	end

	// the level state loads only on a day change, the pulse on every program cycle
	assign span_load = scan_tick && new_day;
	assign q_load = scan_tick && (mode_pulse || new_day);

	always_comb begin
		next_q = 1'b0;
		if (mode_pulse) begin
			// high from this tick to the next one: exactly one program cycle
			next_q = new_day && next_pulse;
		end else begin
			next_q = next_span;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			evaluated <= 1'b0;
		end else if (scan_tick) begin
			evaluated <= 1'b1;
		end
	end

	// date and range flag of the previous program cycle, for the day-change test
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			last_date <= ydt_pkg::DATE_RST;
			last_ok <= 1'b0;
		end else if (scan_tick) begin
			last_date <= now;
			last_ok <= now_ok;
		end
	end

	// config writes land at the next day change; that keeps switching on midnight
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			span_on <= 1'b0;
		end else if (span_load) begin
			span_on <= next_span;
		end
	end

	// output: forced off while the timer is disabled
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			timer_q <= 1'b0;
		end else if (!ctrl[ydt_pkg::CTRL_ENABLE]) begin
			timer_q <= 1'b0;
		end else if (q_load) begin
			timer_q <= next_q;
		end
	end
endmodule : ydt_timer

// ### ydt_timer_asserts.sv
// ydt_timer_chk: port-level checks for the yearly date timer.
// assumes it is bound to ydt_timer and sees only that module's ports.
`timescale 1ns/10ps
module ydt_timer_chk (
	input wire logic clk_sys, // clock
	input wire logic reset, // sync reset
	input wire ydt_pkg::ydt_apb_req_t apb_req, // apb request
	input wire logic pready, // apb ready
	input wire logic [31:0] prdata, // read data
	input wire logic pslverr, // apb error
	input wire ydt_pkg::ydt_rtc_t rtc_now, // rtc time
	input wire logic scan_tick, // program cycle
	input wire logic timer_q // output
);
	logic wr_acc;
	logic rd_set;
	assign wr_acc = apb_req.psel & apb_req.penable & apb_req.pwrite;
	assign rd_set = apb_req.psel & !apb_req.penable & !apb_req.pwrite;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	sequence s_date_wr;
		apb_req.psel && !apb_req.penable && apb_req.pwrite &&
		(apb_req.paddr == ydt_pkg::OFS_ON_DATE || apb_req.paddr == ydt_pkg::OFS_OFF_DATE);
	endsequence
	property p_year;
		s_date_wr ##0 (apb_req.pwdata[27:16] > ydt_pkg::YEAR_MAX ||
		apb_req.pwdata[27:16] < ydt_pkg::YEAR_MIN) |=> pslverr;
	endproperty
	property p_month;
		s_date_wr ##0 (apb_req.pwdata[11:8] == 4'h0 || apb_req.pwdata[11:8] > 4'hC) |=> pslverr;
	endproperty
	property p_day;
		s_date_wr ##0 (apb_req.pwdata[4:0] == 5'h00) |=> pslverr;
	endproperty
	property p_rtc_range;
		scan_tick && (rtc_now.year > ydt_pkg::YEAR_MAX || rtc_now.year < ydt_pkg::YEAR_MIN)
		|=> !timer_q;
	endproperty
	property p_rst_q;
		disable iff (1'b0) reset |=> !timer_q;
	endproperty
	property p_rise;
		$rose(timer_q) |-> $past(scan_tick);
	endproperty
	property p_fall;
		$fell(timer_q) |-> $past(scan_tick) || $past(wr_acc, 2) || $past(reset);
	endproperty
	property p_hold;
		!scan_tick && !wr_acc && !$past(wr_acc) |=> $stable(timer_q);
	endproperty
	property p_status;
		rd_set && apb_req.paddr == ydt_pkg::OFS_STATUS |=> prdata[0] == $past(timer_q);
	endproperty
	property p_unmapped;
		rd_set && apb_req.paddr > ydt_pkg::OFS_STATUS |=> pslverr && prdata == 32'h0000_0000;
	endproperty
	a_year: assert property (p_year) else $error("bad year accepted");
	a_month: assert property (p_month) else $error("bad month accepted");
	a_day: assert property (p_day) else $error("bad day accepted");
	a_rtc_range: assert property (p_rtc_range) else $error("on outside years");
	a_rst_q: assert property (p_rst_q) else $error("output on in reset");
	a_rise: assert property (p_rise) else $error("rise without tick");
	a_fall: assert property (p_fall) else $error("fall without cause");
	a_hold: assert property (p_hold) else $error("output moved between ticks");
	a_status: assert property (p_status) else $error("status bit wrong");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read answered");
endmodule : ydt_timer_chk
bind ydt_timer ydt_timer_chk u_chk (.clk_sys(clk_sys), .reset(reset), .apb_req(apb_req),
	.pready(pready), .prdata(prdata), .pslverr(pslverr), .rtc_now(rtc_now),
	.scan_tick(scan_tick), .timer_q(timer_q));

// ### tb_yearly_date_timer.sv
// tb_yearly_date_timer: self-checking bench for ydt_timer over apb and rtc dates.
// assumes zero-wait apb and timer_q valid one cycle after scan_tick.
`timescale 1ns/10ps
module tb_yearly_date_timer;
	localparam logic [7:0] A_ON = ydt_pkg::OFS_ON_DATE;
	localparam logic [7:0] A_OFF = ydt_pkg::OFS_OFF_DATE;
	localparam logic [32:0] OK = 33'h0_0000_0000;
	localparam logic [32:0] ERR = 33'h1_0000_0000;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	ydt_pkg::ydt_apb_req_t apb_req = '0;
	ydt_pkg::ydt_rtc_t rtc_now = '0;
	logic scan_tick = 1'b0;
	logic tick_d = 1'b0;
	logic rnd = 1'b0;
	logic pready, pslverr, timer_q;
	logic [31:0] prdata;
	int miscompares = 0;
	int cmp_count = 0;
	logic [32:0] q_apb[$];
	logic q_tmr[$];
	always #4 clk_sys = ~clk_sys;
	ydt_timer u_dut (.clk_sys(clk_sys), .reset(reset), .apb_req(apb_req), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .rtc_now(rtc_now), .scan_tick(scan_tick),
		.timer_q(timer_q));
	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic tally_and_finish();
		if (miscompares == 0 && cmp_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : tally_and_finish
	function automatic logic [31:0] dw(input logic [11:0] y, input logic [3:0] m,
		input logic [4:0] d);
		return {4'h0, y, 4'h0, m, 3'h0, d};
	endfunction : dw
	// writes are judged on pslverr alone, reads on both
	always @(posedge clk_sys) begin
		if (apb_req.psel && apb_req.penable && pready)
			check({pslverr, apb_req.pwrite ? 32'h0000_0000 : prdata}, q_apb.pop_front());
		if (tick_d)
			check({32'h0000_0000, timer_q}, {32'h0000_0000, q_tmr.pop_front()});
		tick_d <= scan_tick;
	end
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [32:0] e);
		int n = 0;
		q_apb.push_back(e);
		apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge clk_sys);
		apb_req.penable <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
		end while (!pready && n < 16);
		if (n >= 16) begin
			miscompares++;
			tally_and_finish();
		end
		apb_req <= '0;
		@(posedge clk_sys);
	endtask : apb
	// level modes get a random hour, pulse modes midnight unless rnd is forced
	task automatic day(input logic [11:0] y, input logic [3:0] m, input logic [4:0] d, input logic e);
		q_tmr.push_back(e);
		rtc_now <= {y, m, d, rnd ? 5'($urandom_range(23, 1)) : 5'h00, 6'h00};
		scan_tick <= 1'b1;
		@(posedge clk_sys);
		scan_tick <= 1'b0;
		repeat (2) @(posedge clk_sys);
	endtask : day
	task automatic cfg(input logic [3:0] c, input logic [31:0] on, input logic [31:0] off);
		apb(1'b1, A_ON, on, OK);
		apb(1'b1, A_OFF, off, OK);
		apb(1'b1, ydt_pkg::OFS_CTRL, {28'h000_0000, c}, OK);
		apb(1'b0, ydt_pkg::OFS_CTRL, 32'h0000_0000, {1'b0, 28'h000_0000, c});
		rnd = !c[2];
	endtask : cfg
	initial begin
		void'($urandom(32'h0000_3349));
		repeat (2) @(posedge clk_sys);
		reset <= 1'b0;
		apb(1'b0, ydt_pkg::OFS_CTRL, 32'h0000_0000, OK);
		apb(1'b0, 8'h10, 32'($urandom), ERR);
		apb(1'b1, A_ON, dw(12'h834, 4'h6, 5'h01), ERR);
		apb(1'b1, A_ON, dw(12'h7D8, 4'hD, 5'h01), ERR);
		apb(1'b1, A_ON, dw(12'h7D8, 4'h6, 5'h00), ERR);
		apb(1'b1, A_OFF, dw(12'h833, 4'hC, 5'h1F), OK);
		apb(1'b0, A_OFF, 32'h0000_0000, {1'b0, dw(12'h833, 4'hC, 5'h1F)});
		apb(1'b0, A_ON, 32'h0000_0000, {1'b0, dw(12'h7D0, 4'h1, 5'h01)});
		day(12'h7D8, 4'h6, 5'h01, 1'b0);
		cfg(4'h8, dw(12'h7D0, 4'h1, 5'h01), dw(12'h833, 4'hC, 5'h1F));
		day(12'h7CF, 4'h6, 5'h01, 1'b0);
		day(12'h802, 4'h6, 5'h06, 1'b1);
		cfg(4'h8, dw(12'h7D8, 4'h6, 5'h01), dw(12'h7DA, 4'h8, 5'h1F));
		day(12'h7D8, 4'h5, 5'h1F, 1'b0);
		day(12'h7D9, 4'hC, 5'h1F, 1'b1);
		day(12'h7DA, 4'h8, 5'h1F, 1'b0);
		cfg(4'hA, dw(12'h7D8, 4'h6, 5'h01), dw(12'h7DA, 4'h8, 5'h1F));
		day(12'h7D7, 4'h6, 5'h01, 1'b0);
		day(12'h7D8, 4'h6, 5'h01, 1'b1);
		apb(1'b0, ydt_pkg::OFS_STATUS, 32'h0000_0000, {1'b0, 32'h0000_0007});
		day(12'h7D8, 4'h8, 5'h1F, 1'b0);
		day(12'h7D9, 4'h6, 5'h01, 1'b1);
		day(12'h7DA, 4'h8, 5'h1E, 1'b1);
		day(12'h7DB, 4'h6, 5'h01, 1'b0);
		cfg(4'hA, dw(12'h7D8, 4'hC, 5'h0F), dw(12'h7DA, 4'h1, 5'h07));
		day(12'h7D8, 4'hC, 5'h0F, 1'b1);
		day(12'h7D9, 4'h1, 5'h06, 1'b1);
		day(12'h7D9, 4'h1, 5'h07, 1'b0);
		day(12'h7D9, 4'hC, 5'h0F, 1'b1);
		day(12'h7DA, 4'h1, 5'h07, 1'b0);
		day(12'h7DA, 4'hC, 5'h0F, 1'b0);
		for (int i = 0; i < 2; i++) begin
			cfg(i ? 4'hB : 4'h9, dw(12'h7D8, 4'h1, 5'h01), dw(12'h7DA, 4'h1, 5'h05));
			day(12'h7D8, 4'h3, 5'h01, 1'b1);
			day(12'h7D8, 4'h3, 5'h05, 1'b0);
			day(12'h7DA, 4'hC, 5'h01, 1'b1);
			day(12'h7DA, 4'hC, 5'h05, 1'b0);
			day(12'h7DB, 4'h1, 5'h01, 1'b0);
		end
		cfg(4'h9, dw(12'h7D8, 4'h1, 5'h14), dw(12'h7DA, 4'h1, 5'h05));
		day(12'h7D8, 4'h1, 5'h03, 1'b0);
		day(12'h7D8, 4'h2, 5'h03, 1'b1);
		apb(1'b1, ydt_pkg::OFS_CTRL, 32'h0000_0001, OK);
		apb(1'b0, ydt_pkg::OFS_STATUS, 32'h0000_0000, {1'b0, 32'h0000_0006});
		apb(1'b1, ydt_pkg::OFS_CTRL, 32'h0000_0009, OK);
		day(12'h7DA, 4'hC, 5'h19, 1'b0);
		day(12'h7DB, 4'h3, 5'h19, 1'b0);
		day(12'h7D7, 4'h3, 5'h03, 1'b0);
		cfg(4'hC, dw(12'h7D8, 4'h3, 5'h0F), dw(12'h7DA, 4'h8, 5'h1F));
		day(12'h7D8, 4'h3, 5'h0E, 1'b0);
		day(12'h7D8, 4'h3, 5'h0F, 1'b1);
		day(12'h7D8, 4'h3, 5'h0F, 1'b0);
		day(12'h7D9, 4'h3, 5'h0F, 1'b0);
		cfg(4'hE, dw(12'h7D8, 4'h3, 5'h0F), dw(12'h7DA, 4'h1, 5'h01));
		rnd = 1'b1;
		day(12'h7D8, 4'h3, 5'h0F, 1'b0);
		rnd = 1'b0;
		day(12'h7D9, 4'h3, 5'h0F, 1'b1);
		day(12'h7D9, 4'h3, 5'h10, 1'b0);
		day(12'h7DA, 4'h3, 5'h0F, 1'b1);
		day(12'h7DB, 4'h3, 5'h0F, 1'b0);
		tally_and_finish();
	end
endmodule : tb_yearly_date_timer
